// ---- gpp_regs.vh ----
// Register map and constants for the eight-pin I/O port block.
// Assumes word-aligned AXI4-Lite byte addresses, 32-bit data.
`ifndef GPP_REGS_VH
`define GPP_REGS_VH

// Register byte offsets
`define GPP_OFF_DM0 12'h000
`define GPP_OFF_DM1 12'h004
`define GPP_OFF_DM2 12'h008
`define GPP_OFF_DATA 12'h00C
`define GPP_OFF_BYP 12'h010
`define GPP_OFF_SLEW 12'h014
`define GPP_OFF_INDIS 12'h018
`define GPP_OFF_CTRL 12'h01C
`define GPP_OFF_PINST 12'h020
`define GPP_OFF_IRQST 12'h024
`define GPP_OFF_IRQLO 12'h028
`define GPP_OFF_IRQHI 12'h02C
`define GPP_OFF_OESEL 12'h030
`define GPP_OFF_REGOUT 12'h034
`define GPP_OFF_RSTCFG 12'h038
`define GPP_OFF_PIN0 12'h040
// Upper bits of the word index that mark the pin-form block
`define GPP_PIN_BASE_HI 3'h2

// Drive mode codes
`define GPP_DM_HIZ_ANA 3'h0
`define GPP_DM_HIZ_DIG 3'h1
`define GPP_DM_RES_UP 3'h2
`define GPP_DM_RES_DN 3'h3
`define GPP_DM_OD_LO 3'h4
`define GPP_DM_OD_HI 3'h5
`define GPP_DM_STRONG 3'h6
`define GPP_DM_RES_UPDN 3'h7

// Edge select codes
`define GPP_EDGE_OFF 2'h0
`define GPP_EDGE_RISE 2'h1
`define GPP_EDGE_FALL 2'h2
`define GPP_EDGE_BOTH 2'h3

// Pin-form field positions
`define GPP_PF_DATA 0
`define GPP_PF_PIN 1
`define GPP_PF_DM_LO 2
`define GPP_PF_DM_HI 4
`define GPP_PF_INDIS 5
`define GPP_PF_BYP 6
`define GPP_PF_SLEW 7

// Answers
`define GPP_RESP_OKAY 2'h0
`define GPP_RESP_SLVERR 2'h2

`endif

// ---- gpp_pin_drv.v ----
// Single pin driver: maps drive mode and data to pad controls.
// Assumes mode and config inputs come from port registers on aclk; aux_oe and bypass data arrive unregistered.
`timescale 1ns/10ps
`include "gpp_regs.vh"

module gpp_pin_drv (
    // Mode and data
    input wire [2:0] drive_mode,
    input wire data,
    input wire aux_oe,
    input wire bidir_en,
    input wire reg_out,
    input wire slew_slow,
    input wire in_dis,
    // Pad controls
    output reg pad_out,
    output reg pad_oe_n,
    output reg pull_up,
    output reg pull_dn,
    output reg in_en,
    output reg slew_eff
);
    reg [2:0] eff_mode;
    always @* begin
        // Aux OE low forces digital input in bidir mode, except from analog HiZ
        eff_mode = drive_mode;
        if (bidir_en && !aux_oe &&
            drive_mode != `GPP_DM_HIZ_ANA) begin
            eff_mode = `GPP_DM_HIZ_DIG;
        end
        // Regulated output has no resistive modes; fall back to HiZ
        if (reg_out && (eff_mode == `GPP_DM_RES_UP ||
            eff_mode == `GPP_DM_RES_DN ||
            eff_mode == `GPP_DM_RES_UPDN)) begin
            eff_mode = `GPP_DM_HIZ_DIG;
        end
        pad_out = data;
        pad_oe_n = 1'b1;
        pull_up = 1'b0;
        pull_dn = 1'b0;
        in_en = !in_dis;
        slew_eff = 1'b0;
        case (eff_mode)
            `GPP_DM_HIZ_ANA: begin
                in_en = 1'b0;
            end
            `GPP_DM_HIZ_DIG: begin
                pad_oe_n = 1'b1;
            end
            `GPP_DM_RES_UP: begin
                pad_oe_n = data;
                pull_up = data;
            end
            `GPP_DM_RES_DN: begin
                pad_oe_n = !data;
                pull_dn = !data;
            end
            `GPP_DM_OD_LO: begin
                pad_oe_n = data;
                slew_eff = slew_slow;
            end
            `GPP_DM_OD_HI: begin
                pad_oe_n = !data;
                slew_eff = slew_slow;
            end
            `GPP_DM_STRONG: begin
                pad_oe_n = 1'b0;
                slew_eff = slew_slow;
            end
            `GPP_DM_RES_UPDN: begin
                pull_up = data;
                pull_dn = !data;
            end
            default: begin
                pad_oe_n = 1'b1;
            end
        endcase
    end
endmodule // gpp_pin_drv

// ---- gpp_port.v ----
// Eight-pin I/O port: drive modes, bypass, bidir, slew, edge irq.
// Assumes AXI4-Lite master on aclk; pad inputs are asynchronous.
`timescale 1ns/10ps
`include "gpp_regs.vh"

module gpp_port #(
    parameter NPIN = 8,
    parameter NAUX = 16
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Routed logic signals
    input wire [NPIN-1:0] bypass_data,
    input wire [NAUX-1:0] aux_oe_bus,
    // Nonvolatile reset configuration
    input wire [2*NPIN-1:0] nv_reset_cfg,
    // Pads
    input wire [NPIN-1:0] pad_in,
    output reg [NPIN-1:0] pad_out,
    output reg [NPIN-1:0] pad_oe_n,
    output reg [NPIN-1:0] pad_pull_up,
    output reg [NPIN-1:0] pad_pull_dn,
    output reg [NPIN-1:0] pad_in_en,
    output reg [NPIN-1:0] pad_slew_slow,
    output reg pad_lvttl_sel,
    output reg pad_hyst_en,
    // Routed pin inputs and irq
    output reg [NPIN-1:0] pin_to_logic,
    output reg port_irq
);
    // Configuration state in port form; one bit per pin except oe_sel_r (four), rst_cfg_r (two) and the single lvttl_r and cfg_load_r
    reg [NPIN-1:0] dm0_r, dm1_r, dm2_r;
    reg [NPIN-1:0] data_r, byp_r, slew_r, indis_r, bidir_r, regout_r;
    reg [NPIN-1:0] edge_lo_r, edge_hi_r;
    reg [NPIN-1:0] irq_st_r;
    reg [4*NPIN-1:0] oe_sel_r;
    reg [2*NPIN-1:0] rst_cfg_r;
    reg lvttl_r;
    reg cfg_load_r;
    // Input path
    reg [NPIN-1:0] sync1_r, sync2_r, prev_r;
    // Bus state
    reg [11:0] aw_addr_r;
    reg aw_have_r, w_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire [NPIN-1:0] d_out, oe_n, pu, pd, ien, slw;
    wire [NPIN-1:0] rise, fall, hit;
    reg [31:0] rd_val;
    reg rd_ok;
    reg wr_ok;
    wire wr_go;
    wire rd_go;

    // Two stages: pad levels are asynchronous to aclk
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= {NPIN{1'b0}};
            sync2_r <= {NPIN{1'b0}};
            prev_r <= {NPIN{1'b0}};
        end else begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Per-pin driver and edge detection
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
            wire [3:0] sel = oe_sel_r[4*gi+3:4*gi];
            wire src = byp_r[gi] ? bypass_data[gi] : data_r[gi];
            gpp_pin_drv u_drv (
                .drive_mode({dm2_r[gi], dm1_r[gi], dm0_r[gi]}),
                .data(src),
                .aux_oe(aux_oe_bus[sel]),
                .bidir_en(bidir_r[gi]),
                .reg_out(regout_r[gi]),
                .slew_slow(slew_r[gi]),
                .in_dis(indis_r[gi]),
                .pad_out(d_out[gi]),
                .pad_oe_n(oe_n[gi]),
                .pull_up(pu[gi]),
                .pull_dn(pd[gi]),
                .in_en(ien[gi]),
                .slew_eff(slw[gi])
            );
            // Edge only; levels are left to external logic
            assign rise[gi] = sync2_r[gi] & ~prev_r[gi];
            assign fall[gi] = ~sync2_r[gi] & prev_r[gi];
            assign hit[gi] = ien[gi] & (
                (edge_lo_r[gi] & rise[gi]) | (edge_hi_r[gi] & fall[gi]));
        end
    endgenerate

    // Registered pad outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            pad_out <= {NPIN{1'b0}};
            pad_oe_n <= {NPIN{1'b1}};
            pad_pull_up <= {NPIN{1'b0}};
            pad_pull_dn <= {NPIN{1'b0}};
            pad_in_en <= {NPIN{1'b0}};
            pad_slew_slow <= {NPIN{1'b0}};
            pad_lvttl_sel <= 1'b0;
            pad_hyst_en <= 1'b1;
            pin_to_logic <= {NPIN{1'b0}};
            port_irq <= 1'b0;
        end else begin
            pad_out <= d_out;
            pad_oe_n <= oe_n;
            pad_pull_up <= pu;
            pad_pull_dn <= pd;
            pad_in_en <= ien;
            pad_slew_slow <= slw;
            pad_lvttl_sel <= lvttl_r;
            pad_hyst_en <= 1'b1;
            pin_to_logic <= sync2_r & ien;
            // No clock gating here, so edges still flag in sleep
            port_irq <= |irq_st_r;
        end
    end

    // Read decode; pin state and data are separate registers
    wire [11:0] rd_addr_w = s_axi_araddr;
    wire [5:0] pidx = rd_addr_w[7:2];
    wire [2:0] pin_sel = pidx[2:0];
    // Upper and byte bits must be zero, so the pin block has no aliases
    wire rd_hi_ok = {rd_addr_w[11:8], rd_addr_w[1:0]} == 6'h00;
    always @* begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        case (rd_addr_w)
            `GPP_OFF_DM0: rd_val[NPIN-1:0] = dm0_r;
            `GPP_OFF_DM1: rd_val[NPIN-1:0] = dm1_r;
            `GPP_OFF_DM2: rd_val[NPIN-1:0] = dm2_r;
            `GPP_OFF_DATA: rd_val[NPIN-1:0] = data_r;
            `GPP_OFF_BYP: rd_val[NPIN-1:0] = byp_r;
            `GPP_OFF_SLEW: rd_val[NPIN-1:0] = slew_r;
            `GPP_OFF_INDIS: rd_val[NPIN-1:0] = indis_r;
            `GPP_OFF_CTRL: rd_val[NPIN:0] = {bidir_r, lvttl_r};
            `GPP_OFF_PINST: rd_val[NPIN-1:0] = sync2_r & ien;
            `GPP_OFF_IRQST: rd_val[NPIN-1:0] = irq_st_r;
            `GPP_OFF_IRQLO: rd_val[NPIN-1:0] = edge_lo_r;
            `GPP_OFF_IRQHI: rd_val[NPIN-1:0] = edge_hi_r;
            `GPP_OFF_OESEL: rd_val[4*NPIN-1:0] = oe_sel_r;
            `GPP_OFF_REGOUT: rd_val[NPIN-1:0] = regout_r;
            `GPP_OFF_RSTCFG: rd_val[2*NPIN-1:0] = rst_cfg_r;
            default: begin
                if (rd_hi_ok && pidx[5:3] == `GPP_PIN_BASE_HI &&
                    NPIN == 8) begin
                    rd_val[7:0] = {slew_r[pin_sel], byp_r[pin_sel],
                        indis_r[pin_sel], dm2_r[pin_sel], dm1_r[pin_sel],
                        dm0_r[pin_sel], sync2_r[pin_sel],
                        data_r[pin_sel]};
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // Write channel handshake; address and data in either order
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    wire [5:0] widx = aw_addr_r[7:2];
    wire [2:0] wpin = widx[2:0];
    wire wr_pin = ({aw_addr_r[11:8], aw_addr_r[1:0]} == 6'h00) &&
        (widx[5:3] == `GPP_PIN_BASE_HI);
    wire w_lane0 = w_strb_r[0];
    // Status clears only on read, and a new edge wins over the clear
    wire rd_irq = rd_go && s_axi_araddr == `GPP_OFF_IRQST;

    always @* begin
        case (aw_addr_r)
            `GPP_OFF_DM0, `GPP_OFF_DM1, `GPP_OFF_DM2, `GPP_OFF_DATA,
            `GPP_OFF_BYP, `GPP_OFF_SLEW, `GPP_OFF_INDIS, `GPP_OFF_CTRL,
            `GPP_OFF_IRQLO, `GPP_OFF_IRQHI, `GPP_OFF_OESEL,
            `GPP_OFF_REGOUT, `GPP_OFF_RSTCFG,
            `GPP_OFF_PINST, `GPP_OFF_IRQST: wr_ok = 1'b1;
            default: wr_ok = wr_pin;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GPP_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `GPP_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            dm0_r <= {NPIN{1'b0}};
            dm1_r <= {NPIN{1'b0}};
            dm2_r <= {NPIN{1'b0}};
            data_r <= {NPIN{1'b0}};
            byp_r <= {NPIN{1'b0}};
            slew_r <= {NPIN{1'b0}};
            indis_r <= {NPIN{1'b0}};
            bidir_r <= {NPIN{1'b0}};
            regout_r <= {NPIN{1'b0}};
            edge_lo_r <= {NPIN{1'b0}};
            edge_hi_r <= {NPIN{1'b0}};
            irq_st_r <= {NPIN{1'b0}};
            oe_sel_r <= {4*NPIN{1'b0}};
            rst_cfg_r <= {2*NPIN{1'b0}};
            lvttl_r <= 1'b0;
            cfg_load_r <= 1'b1;
        end else begin
            // One cycle after release, apply stored reset config
            cfg_load_r <= 1'b0;
            if (cfg_load_r) begin
                rst_cfg_r <= nv_reset_cfg;
            end
            if (cfg_load_r) begin
                // Per pin: 01 pull-down, 10 pull-up, else analog HiZ
                dm0_r <= ~nv_reset_cfg[2*NPIN-1:NPIN]
                    & nv_reset_cfg[NPIN-1:0];
                dm1_r <= nv_reset_cfg[2*NPIN-1:NPIN]
                    ^ nv_reset_cfg[NPIN-1:0];
                data_r <= nv_reset_cfg[2*NPIN-1:NPIN]
                    & ~nv_reset_cfg[NPIN-1:0];
            end
            s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
                if (wr_ok && w_lane0 && !cfg_load_r) begin
                    case (aw_addr_r)
                        `GPP_OFF_DM0: dm0_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_DM1: dm1_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_DM2: dm2_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_DATA: data_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_BYP: byp_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_SLEW: slew_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_INDIS: indis_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_CTRL: begin
                            lvttl_r <= w_data_r[0];
                            bidir_r <= w_data_r[NPIN:1];
                        end
                        `GPP_OFF_IRQLO: edge_lo_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_IRQHI: edge_hi_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_OESEL: oe_sel_r <= w_data_r[4*NPIN-1:0];
                        `GPP_OFF_REGOUT: regout_r <= w_data_r[NPIN-1:0];
                        `GPP_OFF_RSTCFG: rst_cfg_r <= w_data_r[2*NPIN-1:0];
                        default: begin
                            if (wr_pin) begin
                                data_r[wpin] <= w_data_r[`GPP_PF_DATA];
                                dm0_r[wpin] <= w_data_r[`GPP_PF_DM_LO];
                                dm1_r[wpin] <= w_data_r[`GPP_PF_DM_LO+1];
                                dm2_r[wpin] <= w_data_r[`GPP_PF_DM_HI];
                                indis_r[wpin] <= w_data_r[`GPP_PF_INDIS];
                                byp_r[wpin] <= w_data_r[`GPP_PF_BYP];
                                slew_r[wpin] <= w_data_r[`GPP_PF_SLEW];
                            end
                        end
                    endcase
                end
            end
            // Read channel, one outstanding
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
            end
            irq_st_r <= (rd_irq ? {NPIN{1'b0}} : irq_st_r) | hit;
        end
    end
endmodule // gpp_port

// ---- gpp_port_properties.sv ----
// Checker for the I/O port block: pad controls, bus answers, irq.
// Assumes bind onto gpp_port; sees its ports only.
`timescale 1ns/10ps
module gpp_port_chk #(
    parameter NPIN = 8
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    // Pads and irq
    input wire [NPIN-1:0] pad_in,
    input wire [NPIN-1:0] pad_oe_n,
    input wire [NPIN-1:0] pad_pull_up,
    input wire [NPIN-1:0] pad_pull_dn,
    input wire [NPIN-1:0] pad_in_en,
    input wire [NPIN-1:0] pad_slew_slow,
    input wire [NPIN-1:0] pin_to_logic,
    input wire port_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Plain signal so that past depth applies to a net
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    sequence aw_taken; s_axi_awvalid && s_axi_awready; endsequence
    sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    AST_RST_PADS: assert property ($rose(aresetn) |-> (&pad_oe_n) &&
        pad_pull_up == 0 && pad_pull_dn == 0 && pad_in_en == 0 && !port_irq)
        else $error("pads not analog hiz after reset");
    AST_RES_NO_DRIVE: assert property (((pad_pull_up & pad_pull_dn) |
        (~pad_oe_n & (pad_pull_up | pad_pull_dn))) == 0)
        else $error("resistor state overlaps driver");
    AST_SLEW_RES: assert property ((pad_slew_slow &
        (pad_pull_up | pad_pull_dn)) == 0)
        else $error("slow slew in resistive state");
    AST_IN_GATE: assert property ((pin_to_logic & ~pad_in_en &
        ~$past(pad_in_en)) == 0) else $error("pin value with buffer off");
    AST_B_ANSWER: assert property (aw_taken |-> ##[1:4] s_axi_bvalid)
        else $error("no write answer");
    AST_R_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
        else $error("no read answer");
    AST_IRQ_FALL: assert property ($fell(port_irq) |-> $past(ar_hs) ||
        $past(ar_hs, 2) || $past(ar_hs, 3)) else $error("irq dropped alone");
    AST_IRQ_RISE: assert property ($rose(port_irq) |->
        $past(pad_in, 3) != $past(pad_in, 4) ||
        $past(pad_in, 4) != $past(pad_in, 5) ||
        $past(pad_in, 5) != $past(pad_in, 6)) else $error("irq without edge");
endmodule // gpp_port_chk

bind gpp_port gpp_port_chk #(.NPIN(NPIN)) chk_u (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .pad_in, .pad_oe_n, .pad_pull_up,
    .pad_pull_dn, .pad_in_en, .pad_slew_slow, .pin_to_logic, .port_irq);

// ---- gpp_board_model.sv ----
// Board side of the port: resolves each pad from all drivers.
// Assumes the bench supplies the external drive per pin.
`timescale 1ns/10ps
module gpp_board_model #(
    parameter NPIN = 8
) (
    // Clock
    input wire aclk,
    // Pad controls
    input wire [NPIN-1:0] pad_out,
    input wire [NPIN-1:0] pad_oe_n,
    input wire [NPIN-1:0] pad_pull_up,
    input wire [NPIN-1:0] pad_pull_dn,
    // External drive
    input wire [NPIN-1:0] ext_en,
    input wire [NPIN-1:0] ext_val,
    // Resolved level
    output wire [NPIN-1:0] pad_level
);
    // Undriven pad wanders, so a stale value never passes
    reg [NPIN-1:0] float_r = '0;
    always @(posedge aclk) begin
        float_r <= ~float_r;
    end
    // Strong driver wins; resistor loses to the outside
    assign pad_level = (~pad_oe_n & pad_out) |
        (pad_oe_n & ext_en & ext_val) |
        (pad_oe_n & ~ext_en & (pad_pull_up | (~pad_pull_dn & float_r)));
endmodule // gpp_board_model

// ---- testbench.sv ----
// Self-checking bench for the eight-pin I/O port block.
// Assumes gpp_port, its checker bind and the board model.
`timescale 1ns/10ps
`include "gpp_regs.vh"
module testbench;
    reg aclk = 1'h0;
    reg aresetn = 1'h0;
    reg [11:0] s_axi_awaddr = 12'h000;
    reg [11:0] s_axi_araddr = 12'h000;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    reg [7:0] bypass_data = 8'h00, ext_en = 8'hFF, ext_val = 8'h00;
    reg [15:0] aux_oe_bus = 16'h0000, nv_reset_cfg = 16'h0201;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, pad_lvttl_sel, pad_hyst_en, port_irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_dn;
    wire [7:0] pad_in_en, pad_slew_slow, pin_to_logic;
    int err_count = 0, checks_done = 0, cyc = 0, md[8], i, j;
    reg [31:0] rnd = 32'h4EA0, rdv;
    reg [7:0] slw = 8'h00;
    reg [1:0] resp;

    gpp_port dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bypass_data,
        .aux_oe_bus, .nv_reset_cfg, .pad_in, .pad_out, .pad_oe_n,
        .pad_pull_up, .pad_pull_dn, .pad_in_en, .pad_slew_slow,
        .pad_lvttl_sel, .pad_hyst_en, .pin_to_logic, .port_irq);
    gpp_board_model #(.NPIN(8)) board_u (.aclk, .pad_out, .pad_oe_n,
        .pad_pull_up, .pad_pull_dn, .ext_en, .ext_val, .pad_level(pad_in));

    initial forever #5 aclk = ~aclk;

    function automatic [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction

    task tally_and_finish;
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish;
        end
    end

    task cmp8(input string nm, input [7:0] e, input [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task cmp32(input string nm, input [31:0] e, input [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task axi_wr(input [11:0] a, input [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task axi_rd(input [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task rd_cmp(input [11:0] a, input [31:0] e);
        axi_rd(a);
        cmp32($sformatf("reg %h", a), e, rdv);
    endtask

    task set_mode(input [2:0] m);
        axi_wr(`GPP_OFF_DM0, {24'h0, {8{m[0]}}});
        axi_wr(`GPP_OFF_DM1, {24'h0, {8{m[1]}}});
        axi_wr(`GPP_OFF_DM2, {24'h0, {8{m[2]}}});
        for (i = 0; i < 8; i++) md[i] = m;
    endtask

    // Reference pad controls from mode, data and slew per pin
    task chk_pads(input [7:0] dv);
        reg [7:0] eo, eu, ed, es, ei;
        int m, d, k;
        for (k = 0; k < 8; k++) begin
            m = md[k];
            d = dv[k];
            eo[k] = !((m == 2 && !d) || (m == 3 && d) || (m == 4 && !d) ||
                (m == 5 && d) || m == 6);
            eu[k] = (m == 2 || m == 7) && d;
            ed[k] = (m == 3 || m == 7) && !d;
            es[k] = m >= 4 && m <= 6 && slw[k];
            ei[k] = m != 0;
        end
        cmp8("pad_oe_n", eo, pad_oe_n);
        cmp8("pad_out", dv & ~eo, pad_out & ~eo);
        cmp8("pad_pull_up", eu, pad_pull_up);
        cmp8("pad_pull_dn", ed, pad_pull_dn);
        cmp8("pad_slew_slow", es, pad_slew_slow);
        cmp8("pad_in_en", ei, pad_in_en);
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        tick(3);
        md = '{3, 2, 0, 0, 0, 0, 0, 0};
        chk_pads(8'h02);
        cmp8("pad_hyst_en", 8'h01, {7'h00, pad_hyst_en});
        rd_cmp(`GPP_OFF_DM1, 32'h3);
        rd_cmp(`GPP_OFF_DATA, 32'h2);
        axi_wr(`GPP_OFF_SLEW, 32'hFF);
        slw = 8'hFF;
        for (j = 0; j < 8; j++) begin
            set_mode(j[2:0]);
            repeat (2) begin
                rnd = xs(rnd);
                axi_wr(`GPP_OFF_DATA, {24'h0, rnd[7:0]});
                tick(3);
                chk_pads(rnd[7:0]);
            end
            rd_cmp(`GPP_OFF_DATA, {24'h0, rnd[7:0]});
        end
        // Regulated output removes the resistor modes
        set_mode(3'h2);
        axi_wr(`GPP_OFF_DATA, 32'hFF);
        axi_wr(`GPP_OFF_REGOUT, 32'hFF);
        tick(3);
        cmp8("pad_pull_up", 8'h00, pad_pull_up);
        cmp8("pad_oe_n", 8'hFF, pad_oe_n);
        axi_wr(`GPP_OFF_REGOUT, 32'h0);
        set_mode(3'h6);
        axi_wr(`GPP_OFF_BYP, 32'hFF);
        bypass_data <= rnd[15:8];
        tick(3);
        chk_pads(rnd[15:8]);
        axi_wr(`GPP_OFF_BYP, 32'h0);
        // Pins listen to the upper aux lines 8..15
        axi_wr(`GPP_OFF_OESEL, 32'hFEDCBA98);
        axi_wr(`GPP_OFF_CTRL, 32'h1FF);
        tick(2);
        cmp8("pad_lvttl_sel", 8'h01, {7'h00, pad_lvttl_sel});
        repeat (4) begin
            rnd = xs(rnd);
            aux_oe_bus <= rnd[15:0];
            tick(3);
            cmp8("pad_oe_n", ~aux_oe_bus[15:8], pad_oe_n);
            cmp8("pad_in_en", 8'hFF, pad_in_en);
        end
        for (j = 0; j < 8; j++) axi_wr(12'(4 * j), 32'h0);
        slw = 8'h00;
        axi_wr(`GPP_OFF_PIN0 + 12'h00C, 32'h19);
        tick(4);
        rd_cmp(`GPP_OFF_DM0, 32'h0);
        rd_cmp(`GPP_OFF_DM2, 32'h8);
        rd_cmp(`GPP_OFF_DATA, 32'h8);
        rd_cmp(`GPP_OFF_PIN0 + 12'h00C, 32'h1B);
        set_mode(3'h1);
        ext_val <= rnd[23:16];
        tick(4);
        rd_cmp(`GPP_OFF_PINST, {24'h0, ext_val});
        cmp8("pin_to_logic", ext_val, pin_to_logic);
        axi_wr(`GPP_OFF_PINST, 32'hFF);
        rd_cmp(`GPP_OFF_DATA, 32'h8);
        axi_wr(12'h100, 32'h1);
        cmp32("bresp", {30'h0, `GPP_RESP_SLVERR}, {30'h0, resp});
        axi_rd(12'h03C);
        cmp32("rresp", {30'h0, `GPP_RESP_SLVERR}, {30'h0, resp});
        axi_wr(`GPP_OFF_INDIS, 32'h0F);
        tick(4);
        cmp8("pad_in_en", 8'hF0, pad_in_en);
        cmp8("pin_to_logic", ext_val & 8'hF0, pin_to_logic);
        axi_wr(`GPP_OFF_INDIS, 32'h0);
        ext_val <= 8'h00;
        tick(8);
        axi_wr(`GPP_OFF_IRQLO, 32'h05);
        axi_wr(`GPP_OFF_IRQHI, 32'h06);
        rd_cmp(`GPP_OFF_IRQST, 32'h0);
        ext_val <= 8'h0F;
        tick(8);
        cmp8("port_irq", 8'h01, {7'h00, port_irq});
        rd_cmp(`GPP_OFF_IRQST, 32'h05 & 32'h0F);
        tick(3);
        rd_cmp(`GPP_OFF_IRQST, 32'h0);
        cmp8("port_irq", 8'h00, {7'h00, port_irq});
        ext_val <= 8'h00;
        tick(8);
        rd_cmp(`GPP_OFF_IRQST, 32'h06 & 32'h0F);
        tally_and_finish;
    end
endmodule // testbench
